// File: rtl/dual_timer_defines.svh
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index
// ----------------------------------------------------------------------------
`define DT_IDX_SERIAL_TIMER 16'hFFC3
`define DT_IDX_CH0_CTRL     16'hFFC8
`define DT_IDX_CH0_CSR      16'hFFC9
`define DT_IDX_CH0_TCA      16'hFFCA
`define DT_IDX_CH0_TCB      16'hFFCB
`define DT_IDX_CH0_CNT      16'hFFCC
`define DT_IDX_CH1_CTRL     16'hFFD0
`define DT_IDX_CH1_CSR      16'hFFD1
`define DT_IDX_CH1_TCA      16'hFFD2
`define DT_IDX_CH1_TCB      16'hFFD3
`define DT_IDX_CH1_CNT      16'hFFD4

// ----------------------------------------------------------------------------
// Reset values, counter maximum and constant read bits
// ----------------------------------------------------------------------------
`define DT_TC_RST           8'hFF
`define DT_CNT_MAX          8'hFF
`define DT_CH0_RSV_BIT      1'b0
`define DT_CH1_RSV_BIT      1'b1

// ----------------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------------
`define DT_CKS_STOP0        3'h0
`define DT_CKS_DIV_A        3'h1
`define DT_CKS_DIV_B        3'h2
`define DT_CKS_DIV_C        3'h3
`define DT_CKS_STOP1        3'h4
`define DT_CKS_EXT_RISE     3'h5
`define DT_CKS_EXT_FALL     3'h6
`define DT_CKS_EXT_BOTH     3'h7
`define DT_CLR_NONE         2'h0
`define DT_CLR_MATCH_A      2'h1
`define DT_CLR_MATCH_B      2'h2
`define DT_CLR_PIN          2'h3
`define DT_OS_KEEP          2'h0
`define DT_OS_LOW           2'h1
`define DT_OS_HIGH          2'h2
`define DT_OS_TOGGLE        2'h3

// ----------------------------------------------------------------------------
// Prescaler: divisor is two to the power of the exponent
// ----------------------------------------------------------------------------
`define DT_PRE_W            11
`define DT_EXP_SLOW_A       4'h3
`define DT_EXP_SLOW_B       4'h6
`define DT_EXP_SLOW_C       4'hA
`define DT_CH0_EXP_FAST_A   4'h1
`define DT_CH0_EXP_FAST_B   4'h5
`define DT_CH0_EXP_FAST_C   4'h8
`define DT_CH1_EXP_FAST_A   4'h1
`define DT_CH1_EXP_FAST_B   4'h7
`define DT_CH1_EXP_FAST_C   4'hB

`define DT_RESP_OKAY        2'h0
`define DT_RESP_SLVERR      2'h2

`endif

// File: rtl/dual_timer_pkg.sv
`include "dual_timer_defines.svh"

package dual_timer_pkg;

  typedef struct packed {
    logic       matchBIrqEnable;
    logic       matchAIrqEnable;
    logic       wrapIrqEnable;
    logic       clearSourceHi;
    logic       clearSourceLo;
    logic [2:0] clockSel;
  } timer_control_reg_t;

  typedef struct packed {
    timer_control_reg_t ctrl;
    logic               matchBFlag;
    logic               matchAFlag;
    logic               wrapFlag;
    logic [3:0]         outSelect;
    logic [7:0]         timeConstantA;
    logic [7:0]         timeConstantB;
    logic [7:0]         upCounter;
    logic               outLevel;
    logic               outOn;
    logic               irqA;
    logic               irqB;
    logic               irqW;
  } chan_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_t;

  typedef struct packed {
    chan_t [1:0]           ch;
    logic [`DT_PRE_W-1:0]  prescale;
    logic [1:0]            prescaleBits;
    logic [3:0]            syncA;
    logic [3:0]            syncB;
    logic [3:0]            syncC;
    logic                  awHeld;
    logic                  awBad;
    logic [15:0]           awIdx;
    logic                  wHeld;
    logic [7:0]            wByte;
    logic                  wLane;
    logic                  awRdy;
    logic                  wRdy;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arRdy;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } state_t;

endpackage : dual_timer_pkg

// File: rtl/dual_8bit_compare_timer.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dual_timer_defines.svh"

// Function
// - Channel 0 codes 0,4 stop; 1-3 divide by 8/64/1024 or 2/32/256.
// - Channel 1 codes 1-3 divide by 8/64/1024 or 2/128/2048; 0,4 stop.
// - Codes 5,6,7 count external rising, falling or both edges.
// - Clear field: none, match A, match B, or external reset rising edge.
// - Overflow request only when its enable bit is set.
// - Match A request only while its enable bit is set.
// - Match B request only while its enable bit is set.
// - Match A flag sets when counter equals constant A.
// - Match B flag sets when counter equals constant B.
// - Status flags clear on written zero; written one has no effect.
// - All four output-select bits zero disables the compare output.
// - Channel 1 mirrors channel 0 except divisors and reserved bit reading one.
module dual_8bit_compare_timer (
  input  wire logic                     clk,        // Peripheral clock.
  input  wire logic                     rst_n,      // Synchronous reset, active low.
  input  wire logic                     ce,         // Clock enable; low freezes all state.
  input  wire dual_timer_pkg::axi_req_t axiReq,     // AXI4-Lite master signals.
  output      dual_timer_pkg::axi_rsp_t axiRsp,     // AXI4-Lite slave signals.
  input  wire logic [1:0]               extClk,     // External clock pin per channel.
  input  wire logic [1:0]               extRst,     // External counter reset pin per channel.
  output      logic [1:0]               cmpOut,     // Compare output level per channel.
  output      logic [1:0]               cmpOutOn,   // Compare output enabled per channel.
  output      logic [1:0]               irqMatchA,  // Match A request per channel.
  output      logic [1:0]               irqMatchB,  // Match B request per channel.
  output      logic [1:0]               irqWrap     // Overflow request per channel.
);
  import dual_timer_pkg::*;

  state_t     st_ff;
  state_t     nxt_st;
  logic [1:0] tick;
  logic [1:0] matchA;
  logic [1:0] matchB;
  logic [1:0] clrNow;
  logic [1:0] wrap;
  logic [1:0] extRise;
  logic [1:0] extFall;
  logic [1:0] rstRise;
  logic [1:0] wrCtrl;
  logic [1:0] wrCsr;
  logic [1:0] wrCnt;
  logic       doWr;
  logic       wrEn;
  logic [8:0] wrLook;
  logic [8:0] rdLook;
  logic [8:0] csr0Look;
  logic [8:0] csr1Look;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // A tick is the cycle in which the divided clock falls, i.e. the low
  // prescaler bits are all ones and roll over on the next edge.
  function automatic logic prescaleTick(input logic [`DT_PRE_W-1:0] pre,
                                        input logic [3:0] expo);
    logic [`DT_PRE_W-1:0] mask;
    mask = ~({`DT_PRE_W{1'b1}} << expo);
    return (pre & mask) == mask;
  endfunction : prescaleTick

  function automatic logic [3:0] divExp(input logic chan, input logic [2:0] sel,
                                        input logic fast);
    logic [3:0] e;
    e = `DT_EXP_SLOW_A;
    if (sel == `DT_CKS_DIV_B) begin
      e = !fast ? `DT_EXP_SLOW_B : (chan ? `DT_CH1_EXP_FAST_B : `DT_CH0_EXP_FAST_B);
    end else if (sel == `DT_CKS_DIV_C) begin
      e = !fast ? `DT_EXP_SLOW_C : (chan ? `DT_CH1_EXP_FAST_C : `DT_CH0_EXP_FAST_C);
    end else begin
      e = !fast ? `DT_EXP_SLOW_A : (chan ? `DT_CH1_EXP_FAST_A : `DT_CH0_EXP_FAST_A);
    end
    return e;
  endfunction : divExp

  // Returns the hit bit on top of the eight data bits.
  function automatic logic [8:0] regRead(input state_t s, input logic [15:0] idx);
    logic [8:0] r;
    r = 9'h000;
    unique case (idx)
      `DT_IDX_SERIAL_TIMER: r = {1'b1, 6'h00, s.prescaleBits};
      `DT_IDX_CH0_CTRL:     r = {1'b1, s.ch[0].ctrl};
      `DT_IDX_CH0_CSR:      r = {1'b1, s.ch[0].matchBFlag, s.ch[0].matchAFlag,
                                 s.ch[0].wrapFlag, `DT_CH0_RSV_BIT, s.ch[0].outSelect};
      `DT_IDX_CH0_TCA:      r = {1'b1, s.ch[0].timeConstantA};
      `DT_IDX_CH0_TCB:      r = {1'b1, s.ch[0].timeConstantB};
      `DT_IDX_CH0_CNT:      r = {1'b1, s.ch[0].upCounter};
      `DT_IDX_CH1_CTRL:     r = {1'b1, s.ch[1].ctrl};
      `DT_IDX_CH1_CSR:      r = {1'b1, s.ch[1].matchBFlag, s.ch[1].matchAFlag,
                                 s.ch[1].wrapFlag, `DT_CH1_RSV_BIT, s.ch[1].outSelect};
      `DT_IDX_CH1_TCA:      r = {1'b1, s.ch[1].timeConstantA};
      `DT_IDX_CH1_TCB:      r = {1'b1, s.ch[1].timeConstantB};
      `DT_IDX_CH1_CNT:      r = {1'b1, s.ch[1].upCounter};
      default:              r = 9'h000;
    endcase
    return r;
  endfunction : regRead

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic lvl;
    logic [1:0] actA;
    logic [1:0] actB;
    lvl    = 1'b0;
    actA   = `DT_OS_KEEP;
    actB   = `DT_OS_KEEP;
    nxt_st = st_ff;
    nxt_st.prescale = st_ff.prescale + `DT_PRE_W'(1);
    nxt_st.syncA = {extRst, extClk};
    nxt_st.syncB = st_ff.syncA;
    nxt_st.syncC = st_ff.syncB;
    extRise = st_ff.syncB[1:0] & ~st_ff.syncC[1:0];
    extFall = ~st_ff.syncB[1:0] & st_ff.syncC[1:0];
    rstRise = st_ff.syncB[3:2] & ~st_ff.syncC[3:2];

    // Write path: address and data may arrive in either order.
    if (axiReq.awvalid && st_ff.awRdy) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awIdx  = axiReq.awaddr[17:2];
      nxt_st.awBad  = (axiReq.awaddr[31:18] != 14'h0000) || (axiReq.awaddr[1:0] != 2'h0);
    end
    if (axiReq.wvalid && st_ff.wRdy) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wByte = axiReq.wdata[7:0];
      nxt_st.wLane = axiReq.wstrb[0];
    end
    doWr   = st_ff.awHeld && st_ff.wHeld && !st_ff.bvalid;
    wrLook = regRead(st_ff, st_ff.awIdx);
    wrEn   = doWr && wrLook[8] && !st_ff.awBad && st_ff.wLane;
    if (doWr) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = (wrLook[8] && !st_ff.awBad) ? `DT_RESP_OKAY : `DT_RESP_SLVERR;
    end else if (st_ff.bvalid && axiReq.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wrEn && st_ff.awIdx == `DT_IDX_SERIAL_TIMER) begin
      nxt_st.prescaleBits = st_ff.wByte[1:0];
    end

    // ------------------------------------------------------------------------
    // Timer channels
    // ------------------------------------------------------------------------
    for (int c = 0; c < 2; c++) begin
      wrCtrl[c] = wrEn && st_ff.awIdx == (c == 0 ? `DT_IDX_CH0_CTRL : `DT_IDX_CH1_CTRL);
      wrCsr[c]  = wrEn && st_ff.awIdx == (c == 0 ? `DT_IDX_CH0_CSR : `DT_IDX_CH1_CSR);
      wrCnt[c]  = wrEn && st_ff.awIdx == (c == 0 ? `DT_IDX_CH0_CNT : `DT_IDX_CH1_CNT);
      unique case (st_ff.ch[c].ctrl.clockSel)
        `DT_CKS_STOP0,
        `DT_CKS_STOP1:    tick[c] = 1'b0;
        `DT_CKS_DIV_A,
        `DT_CKS_DIV_B,
        `DT_CKS_DIV_C:    tick[c] = prescaleTick(st_ff.prescale,
                                    divExp(c[0], st_ff.ch[c].ctrl.clockSel,
                                           st_ff.prescaleBits[c]));
        `DT_CKS_EXT_RISE: tick[c] = extRise[c];
        `DT_CKS_EXT_FALL: tick[c] = extFall[c];
        `DT_CKS_EXT_BOTH: tick[c] = extRise[c] | extFall[c];
      endcase
      matchA[c] = tick[c] && st_ff.ch[c].upCounter == st_ff.ch[c].timeConstantA;
      matchB[c] = tick[c] && st_ff.ch[c].upCounter == st_ff.ch[c].timeConstantB;
      unique case ({st_ff.ch[c].ctrl.clearSourceHi, st_ff.ch[c].ctrl.clearSourceLo})
        `DT_CLR_NONE:    clrNow[c] = 1'b0;
        `DT_CLR_MATCH_A: clrNow[c] = matchA[c];
        `DT_CLR_MATCH_B: clrNow[c] = matchB[c];
        `DT_CLR_PIN:     clrNow[c] = rstRise[c];
      endcase
      wrap[c] = tick[c] && st_ff.ch[c].upCounter == `DT_CNT_MAX && !clrNow[c];

      // A software write to the counter wins over counting and clearing.
      if (wrCnt[c]) begin
        nxt_st.ch[c].upCounter = st_ff.wByte;
      end else if (clrNow[c]) begin
        nxt_st.ch[c].upCounter = 8'h00;
      end else if (tick[c]) begin
        nxt_st.ch[c].upCounter = st_ff.ch[c].upCounter + 8'h01;
      end

      // Flags: a written zero clears, a written one keeps, and a hardware
      // event in the same cycle wins over the clear.
      nxt_st.ch[c].matchBFlag = (st_ff.ch[c].matchBFlag && !(wrCsr[c] && !st_ff.wByte[7]))
                                || matchB[c];
      nxt_st.ch[c].matchAFlag = (st_ff.ch[c].matchAFlag && !(wrCsr[c] && !st_ff.wByte[6]))
                                || matchA[c];
      nxt_st.ch[c].wrapFlag   = (st_ff.ch[c].wrapFlag && !(wrCsr[c] && !st_ff.wByte[5]))
                                || wrap[c];
      if (wrCsr[c]) begin
        nxt_st.ch[c].outSelect = st_ff.wByte[3:0];
      end
      if (wrCtrl[c]) begin
        nxt_st.ch[c].ctrl = st_ff.wByte;
      end
      if (wrEn && st_ff.awIdx == (c == 0 ? `DT_IDX_CH0_TCA : `DT_IDX_CH1_TCA)) begin
        nxt_st.ch[c].timeConstantA = st_ff.wByte;
      end
      if (wrEn && st_ff.awIdx == (c == 0 ? `DT_IDX_CH0_TCB : `DT_IDX_CH1_TCB)) begin
        nxt_st.ch[c].timeConstantB = st_ff.wByte;
      end

      // Compare output: match B acts first, so match A decides a tie.
      lvl  = st_ff.ch[c].outLevel;
      actB = matchB[c] ? st_ff.ch[c].outSelect[3:2] : `DT_OS_KEEP;
      actA = matchA[c] ? st_ff.ch[c].outSelect[1:0] : `DT_OS_KEEP;
      unique case (actB)
        `DT_OS_KEEP:   lvl = lvl;
        `DT_OS_LOW:    lvl = 1'b0;
        `DT_OS_HIGH:   lvl = 1'b1;
        `DT_OS_TOGGLE: lvl = ~lvl;
      endcase
      unique case (actA)
        `DT_OS_KEEP:   lvl = lvl;
        `DT_OS_LOW:    lvl = 1'b0;
        `DT_OS_HIGH:   lvl = 1'b1;
        `DT_OS_TOGGLE: lvl = ~lvl;
      endcase
      nxt_st.ch[c].outLevel = lvl;
      nxt_st.ch[c].outOn    = nxt_st.ch[c].outSelect != 4'h0;

      nxt_st.ch[c].irqW = nxt_st.ch[c].wrapFlag && nxt_st.ch[c].ctrl.wrapIrqEnable;
      nxt_st.ch[c].irqA = nxt_st.ch[c].matchAFlag
                          && nxt_st.ch[c].ctrl.matchAIrqEnable;
      nxt_st.ch[c].irqB = nxt_st.ch[c].matchBFlag
                          && nxt_st.ch[c].ctrl.matchBIrqEnable;
    end

    // Read path answers one cycle after the address is taken.
    rdLook = regRead(st_ff, axiReq.araddr[17:2]);
    if (axiReq.arvalid && st_ff.arRdy) begin
      nxt_st.rvalid = 1'b1;
      if (rdLook[8] && axiReq.araddr[31:18] == 14'h0000 && axiReq.araddr[1:0] == 2'h0) begin
        nxt_st.rdata = {24'h000000, rdLook[7:0]};
        nxt_st.rresp = `DT_RESP_OKAY;
      end else begin
        nxt_st.rdata = 32'h00000000;
        nxt_st.rresp = `DT_RESP_SLVERR;
      end
    end else if (st_ff.rvalid && axiReq.rready) begin
      nxt_st.rvalid = 1'b0;
    end
    nxt_st.awRdy = !nxt_st.awHeld && !nxt_st.bvalid;
    nxt_st.wRdy  = !nxt_st.wHeld && !nxt_st.bvalid;
    nxt_st.arRdy = !nxt_st.rvalid;
  end

  assign csr0Look = regRead(st_ff, `DT_IDX_CH0_CSR);
  assign csr1Look = regRead(st_ff, `DT_IDX_CH1_CSR);

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff       <= '0;
      st_ff.awRdy <= 1'b1;
      st_ff.wRdy  <= 1'b1;
      st_ff.arRdy <= 1'b1;
      for (int c = 0; c < 2; c++) begin
        st_ff.ch[c].timeConstantA <= `DT_TC_RST;
        st_ff.ch[c].timeConstantB <= `DT_TC_RST;
      end
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign axiRsp = '{awready: st_ff.awRdy, wready: st_ff.wRdy, bresp: st_ff.bresp,
                    bvalid: st_ff.bvalid, arready: st_ff.arRdy, rdata: st_ff.rdata,
                    rresp: st_ff.rresp, rvalid: st_ff.rvalid};
  assign cmpOut    = {st_ff.ch[1].outLevel, st_ff.ch[0].outLevel};
  assign cmpOutOn  = {st_ff.ch[1].outOn, st_ff.ch[0].outOn};
  assign irqMatchA = {st_ff.ch[1].irqA, st_ff.ch[0].irqA};
  assign irqMatchB = {st_ff.ch[1].irqB, st_ff.ch[0].irqB};
  assign irqWrap   = {st_ff.ch[1].irqW, st_ff.ch[0].irqW};

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_stop_holds: assert property (
    (ce && (st_ff.ch[0].ctrl.clockSel == `DT_CKS_STOP0
            || st_ff.ch[0].ctrl.clockSel == `DT_CKS_STOP1)
     && !st_ff.ch[0].ctrl.clearSourceHi && !wrCnt[0])
    |=> st_ff.ch[0].upCounter == $past(st_ff.ch[0].upCounter))
    else $error("stopped channel 0 counter moved");

  a_ch1_div_two: assert property (
    (ce && st_ff.ch[1].ctrl.clockSel == `DT_CKS_DIV_A && st_ff.prescaleBits[1]
     && st_ff.prescale[0] && !st_ff.ch[1].ctrl.clearSourceHi
     && !st_ff.ch[1].ctrl.clearSourceLo && !wrCnt[1])
    |=> st_ff.ch[1].upCounter == 8'($past(st_ff.ch[1].upCounter) + 8'h01))
    else $error("channel 1 divide-by-two tick missed");

  a_ext_rise: assert property (
    (ce && st_ff.ch[0].ctrl.clockSel == `DT_CKS_EXT_RISE && extRise[0]
     && !st_ff.ch[0].ctrl.clearSourceHi && !st_ff.ch[0].ctrl.clearSourceLo && !wrCnt[0])
    |=> st_ff.ch[0].upCounter == 8'($past(st_ff.ch[0].upCounter) + 8'h01))
    else $error("external rising edge not counted");

  a_clear_match: assert property (
    (ce && matchA[0] && !st_ff.ch[0].ctrl.clearSourceHi
     && st_ff.ch[0].ctrl.clearSourceLo && !wrCnt[0])
    |=> st_ff.ch[0].upCounter == 8'h00)
    else $error("clear on match A failed");

  a_wrap_gate: assert property (
    !st_ff.ch[0].ctrl.wrapIrqEnable |-> !irqWrap[0])
    else $error("overflow request while disabled");

  a_match_a_gate: assert property (
    irqMatchA[0] |-> st_ff.ch[0].ctrl.matchAIrqEnable && st_ff.ch[0].matchAFlag)
    else $error("match A request without enable");

  a_match_b_gate: assert property (
    irqMatchB[1] |-> st_ff.ch[1].ctrl.matchBIrqEnable && st_ff.ch[1].matchBFlag)
    else $error("match B request without enable");

  a_match_a_flag: assert property (
    (ce && matchA[0]) |=> st_ff.ch[0].matchAFlag)
    else $error("match A flag not set");

  a_match_b_flag: assert property (
    (ce && matchB[0]) ##1 1'b1 |-> st_ff.ch[0].matchBFlag)
    else $error("match B flag not set");

  a_flag_one_write: assert property (
    (ce && wrCsr[0] && st_ff.wByte[7] && !st_ff.ch[0].matchBFlag && !matchB[0])
    |=> !st_ff.ch[0].matchBFlag)
    else $error("writing one set a flag");

  a_flag_zero_write: assert property (
    (ce && wrCsr[0] && !st_ff.wByte[6] && !matchA[0]) |=> !st_ff.ch[0].matchAFlag)
    else $error("writing zero left a flag set");

  a_output_off: assert property (
    st_ff.ch[0].outSelect == 4'h0 |-> !cmpOutOn[0])
    else $error("compare output enabled with zero selects");

  a_reserved_one: assert property (
    csr1Look[4] && !csr0Look[4])
    else $error("reserved status bit reads wrong");

  a_wrap_flag: assert property (
    (ce && tick[0] && st_ff.ch[0].upCounter == `DT_CNT_MAX && !clrNow[0] && !wrCnt[0])
    |=> st_ff.ch[0].wrapFlag && st_ff.ch[0].upCounter == 8'h00)
    else $error("wrap did not set overflow flag");

  a_irq_drops: assert property (
    $fell(st_ff.ch[0].wrapFlag) |-> !irqWrap[0])
    else $error("request stayed after flag cleared");

  c_wrap_irq: cover property (irqWrap[0]);
  c_clear_a: cover property (ce && matchA[0] && clrNow[0]);
  c_ext_both: cover property (ce && st_ff.ch[1].ctrl.clockSel == `DT_CKS_EXT_BOTH && tick[1]);
  c_write_done: cover property (st_ff.bvalid && axiReq.bready);

endmodule : dual_8bit_compare_timer

// File: test/ext_pin_model.sv
`timescale 1ns/1ps
module ext_pin_model (
  input  wire logic       clk,     // Bench clock.
  input  wire logic [1:0] clkReq,  // Toggle request per channel.
  input  wire logic [1:0] rstReq,  // Reset pin level per channel.
  output      logic [1:0] extClk,  // External count clock pins.
  output      logic [1:0] extRst   // External counter reset pins.
);
  initial extClk = 2'h0;
  initial extRst = 2'h0;
  // Pins move only on request, so the count clock stands still between bursts.
  always @(posedge clk) begin
    extClk <= extClk ^ clkReq;
    extRst <= rstReq;
  end
endmodule : ext_pin_model

// File: test/test_dual_8bit_compare_timer.sv
`timescale 1ns/1ps
`include "dual_timer_defines.svh"
module test_dual_8bit_compare_timer;
  import dual_timer_pkg::*;
  logic        clk, rst_n, ce;
  axi_req_t    axiReq;
  axi_rsp_t    axiRsp;
  logic [1:0]  extClk, extRst, cmpOut, cmpOutOn, irqMatchA, irqMatchB, irqWrap;
  logic [1:0]  clkReq, rstReq, lastResp;
  logic [7:0]  v, v0;
  logic [15:0] bs;
  int          badCount, testsRun, cyc, p;
  int          divTab[2][2][3] = '{'{'{8, 64, 1024}, '{2, 32, 256}},
                                   '{'{8, 64, 1024}, '{2, 128, 2048}}};

  dual_8bit_compare_timer i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .axiReq(axiReq),
    .axiRsp(axiRsp), .extClk(extClk), .extRst(extRst), .cmpOut(cmpOut),
    .cmpOutOn(cmpOutOn), .irqMatchA(irqMatchA), .irqMatchB(irqMatchB), .irqWrap(irqWrap));
  ext_pin_model i_pins (.clk(clk), .clkReq(clkReq), .rstReq(rstReq), .extClk(extClk),
    .extRst(extRst));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    axiReq.awaddr  <= {14'h0, idx, 2'h0};
    axiReq.wdata   <= {24'h0, d};
    axiReq.wstrb   <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (axiRsp.bvalid !== 1'b1);
    lastResp = axiRsp.bresp;
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [7:0] d);
    axiReq.araddr  <= {14'h0, idx, 2'h0};
    axiReq.arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (axiRsp.rvalid !== 1'b1);
    d = axiRsp.rdata[7:0];
    lastResp = axiRsp.rresp;
  endtask : rd

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    testsRun++;
    if (g !== e) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk2(input string nm, input logic [1:0] e, input logic [1:0] g);
    testsRun++;
    if (g !== e) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk2

  // Pin edges take a few cycles through the synchronisers, so each toggle waits.
  task automatic pinTog(input int c);
    clkReq[c] <= 1'b1;
    @(posedge clk);
    clkReq[c] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : pinTog

  task automatic stopTest;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stopTest

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      badCount++;
      stopTest();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    axiReq = '0;
    // Response ready stays high, so back-to-back calls never drive it twice in one step.
    axiReq.bready = 1'b1;
    axiReq.rready = 1'b1;
    clkReq = 2'h0;
    rstReq = 2'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rd(i < 5 ? 16'hFFC8 + i : 16'hFFCB + i, v);
      chk8("reset", (i % 5 == 2 || i % 5 == 3) ? 8'hFF : (i == 6 ? 8'h10 : 8'h00), v);
    end
    rd(16'hFFC5, v);
    chk2("resp", `DT_RESP_SLVERR, lastResp);
    // Tick counts over a window of three prescaled periods are exact.
    for (int c = 0; c < 2; c++) for (int b = 0; b < 2; b++) for (int k = 0; k < 5; k++) begin
      bs = c ? 16'hFFD0 : 16'hFFC8;
      p = (k % 4) ? divTab[c][b][k - 1] : 16;
      wr(`DT_IDX_SERIAL_TIMER, b ? 8'h03 : 8'h00);
      wr(bs, k);
      rd(bs + 4, v0);
      repeat (p * 3 - 2) @(posedge clk);
      rd(bs + 4, v);
      chk8("ticks", (k % 4) ? 8'h03 : 8'h00, v - v0);
    end
    for (int c = 0; c < 2; c++) for (int k = 5; k < 8; k++) begin
      bs = c ? 16'hFFD0 : 16'hFFC8;
      wr(bs, k);
      rd(bs + 4, v0);
      repeat (4) pinTog(c);
      rd(bs + 4, v);
      chk8("edges", k == 7 ? 8'h04 : 8'h02, v - v0);
    end
    for (int s = 0; s < 2; s++) begin
      wr(16'hFFC8, 8'h00);
      wr(16'hFFCC, 8'h00);
      wr(16'hFFCA + s, 8'h03);
      wr(16'hFFCB - s, 8'hFF);
      wr(16'hFFC8, s ? 8'h95 : 8'h4D);
      repeat (8) pinTog(0);
      rd(16'hFFCC, v);
      chk8("clear", 8'h00, v);
      rd(16'hFFC9, v);
      chk8("flag", s ? 8'h80 : 8'h40, v);
      chk2("irq", s ? 2'h2 : 2'h1, {irqMatchB[0], irqMatchA[0]});
      wr(16'hFFC9, 8'hE0);
      rd(16'hFFC9, v);
      chk8("ones", s ? 8'h80 : 8'h40, v);
      wr(16'hFFC9, 8'h00);
      rd(16'hFFC9, v);
      chk8("zero", 8'h00, v);
      chk2("irqoff", 2'h0, {irqMatchB[0], irqMatchA[0]});
    end
    // Constant A is 0xFF here, so the wrap tick also matches A.
    wr(16'hFFC8, 8'h05);
    wr(16'hFFCC, 8'hFF);
    repeat (2) pinTog(0);
    rd(16'hFFC9, v);
    chk8("wrap", 8'h60, v);
    chk2("wirq", 2'h0, irqWrap);
    wr(16'hFFC8, 8'h25);
    repeat (2) @(posedge clk);
    chk2("wirq", 2'h1, irqWrap);
    wr(16'hFFC8, 8'h18);
    wr(16'hFFCC, 8'h55);
    rstReq[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rstReq[0] <= 1'b0;
    rd(16'hFFCC, v);
    chk8("pinclr", 8'h00, v);
    wr(16'hFFC9, 8'h03);
    repeat (2) @(posedge clk);
    chk2("outon", 2'h1, cmpOutOn);
    // Second rising edge hits constant A, toggling the output and clearing the counter.
    wr(16'hFFCA, 8'h01);
    wr(16'hFFC8, 8'h0D);
    repeat (4) pinTog(0);
    chk2("outlvl", 2'h1, cmpOut);
    wr(16'hFFC9, 8'h00);
    repeat (2) @(posedge clk);
    chk2("outoff", 2'h0, cmpOutOn);
    // Divide by two with only two enabled edges between the snapshots gives one tick.
    wr(16'hFFC8, 8'h01);
    rd(16'hFFCC, v0);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    rd(16'hFFCC, v);
    chk8("freeze", 8'h01, v - v0);
    stopTest();
  end
endmodule : test_dual_8bit_compare_timer
